// File: wdt_pkg.sv
// Constants and bus types for the seconds watchdog.
// Assumes one 40 MHz system clock and a single host I/O master.
package wdt_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] PORT_INDEX = 16'h002e;
  localparam logic [15:0] PORT_DATA = 16'h002f;
  localparam logic [15:0] PORT_REFRESH = 16'h0440;
  localparam logic [7:0] KEY_UNLOCK = 8'h87;
  localparam logic [7:0] KEY_LOCK = 8'haa;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_UNIT = 8'hf5;
  localparam logic [7:0] IDX_COUNT = 8'hf6;
  localparam logic [7:0] LDN_WATCHDOG = 8'h08;
  localparam logic [7:0] UNIT_SECONDS = 8'h00;
  localparam logic [5:0] TIMEOUT_MASK = 6'h3f;
  localparam logic [7:0] RST_LDN = 8'h00;
  localparam logic [7:0] RST_ACTIVATE = 8'h01;
  localparam logic [7:0] RST_UNIT = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SECOND_S = 1;
  localparam int unsigned CYCLES_PER_SEC = CLK_HZ * SECOND_S;
  localparam logic [5:0] SECS_PER_MIN = 6'h3c;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } wdt_io_req_t;

  typedef enum logic [1:0] {
    CFG_LOCKED = 2'b00,
    CFG_KEY1 = 2'b01,
    CFG_OPEN = 2'b11
  } wdt_cfg_state_t;
endpackage : wdt_pkg

// File: wdt_tick.sv
// One-second tick generator for the watchdog.
// Assumes a free-running system clock of known rate.
`timescale 1ns/1ps
`default_nettype none
module wdt_tick #(
  parameter int unsigned CYCLES_PER_SEC = wdt_pkg::CYCLES_PER_SEC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic restart_in,
  output logic tick_out
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  wire logic wrap = (cnt_q == 32'(CYCLES_PER_SEC - 1));

  // Restart aligns the first second to the refresh
  assign cnt_d = (restart_in || wrap) ? 32'h0000_0000 : cnt_q + 32'h1;
  assign tick_out = wrap && !restart_in;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : wdt_tick
`default_nettype wire

// File: wdt_top.sv
// Watchdog with refresh port and keyed index/data configuration space.
// Assumes host I/O strobes are one-cycle and synchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
module wdt_top #(
  parameter int unsigned CYCLES_PER_SEC = wdt_pkg::CYCLES_PER_SEC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire wdt_pkg::wdt_io_req_t io_req_in,
  input wire logic expire_irq_sel_in,
  output logic [7:0] io_rdata_out,
  output logic cpu_reset_out,
  output logic irq_out,
  output logic active_out
);
  wdt_pkg::wdt_cfg_state_t cfg_q;
  wdt_pkg::wdt_cfg_state_t cfg_d;
  logic [7:0] index_q;
  logic [7:0] ldn_q;
  logic [7:0] activate_reg_q;
  logic [7:0] counter_unit_reg_q;
  logic [7:0] counter_value_reg_q;
  logic [7:0] counter_value_reg_d;
  logic [5:0] minute_q;
  logic [5:0] minute_d;
  logic enable_q;
  logic enable_d;
  logic irq_q;
  logic rst_pulse_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic sec_tick;
  logic [7:0] index_d;
  logic [7:0] ldn_d;
  logic [7:0] activate_reg_d;
  logic [7:0] counter_unit_reg_d;

  wire logic wr_index = io_req_in.wr && io_req_in.addr == wdt_pkg::PORT_INDEX;
  wire logic wr_data = io_req_in.wr && io_req_in.addr == wdt_pkg::PORT_DATA;
  wire logic wr_refresh =
    io_req_in.wr && io_req_in.addr == wdt_pkg::PORT_REFRESH;
  wire logic rd_refresh =
    io_req_in.rd && io_req_in.addr == wdt_pkg::PORT_REFRESH;
  wire logic is_open = (cfg_q == wdt_pkg::CFG_OPEN);
  wire logic is_unlock = io_req_in.wdata == wdt_pkg::KEY_UNLOCK;
  wire logic is_lock = io_req_in.wdata == wdt_pkg::KEY_LOCK;
  wire logic wd_sel = (ldn_q == wdt_pkg::LDN_WATCHDOG);
  wire logic cfg_wr = wr_data && is_open;
  wire logic wr_ldn = cfg_wr && index_q == wdt_pkg::IDX_LDN;
  wire logic wr_act = cfg_wr && wd_sel && index_q == wdt_pkg::IDX_ACTIVATE;
  wire logic wr_unit = cfg_wr && wd_sel && index_q == wdt_pkg::IDX_UNIT;
  wire logic wr_cnt = cfg_wr && wd_sel && index_q == wdt_pkg::IDX_COUNT;
  wire logic [5:0] timeout = io_req_in.wdata[5:0] & wdt_pkg::TIMEOUT_MASK;
  // Any load realigns the second prescaler to the write
  wire logic tick_restart = wr_refresh || wr_cnt;

  // Index only moves while open, so a stray byte cannot retarget data
  assign index_d = (wr_index && is_open) ? io_req_in.wdata : index_q;
  assign ldn_d = wr_ldn ? io_req_in.wdata : ldn_q;
  assign activate_reg_d = wr_act ? io_req_in.wdata : activate_reg_q;
  assign counter_unit_reg_d =
    wr_unit ? io_req_in.wdata : counter_unit_reg_q;

  // Key must arrive on two back-to-back index writes
  always_comb begin
    cfg_d = cfg_q;
    case (cfg_q)
      wdt_pkg::CFG_LOCKED: begin
        if (wr_index && is_unlock) begin
          cfg_d = wdt_pkg::CFG_KEY1;
        end
      end
      wdt_pkg::CFG_KEY1: begin
        if (wr_index) begin
          cfg_d = is_unlock ? wdt_pkg::CFG_OPEN : wdt_pkg::CFG_LOCKED;
        end
      end
      wdt_pkg::CFG_OPEN: begin
        if (wr_index && is_lock) begin
          cfg_d = wdt_pkg::CFG_LOCKED;
        end
      end
      default: begin
        cfg_d = wdt_pkg::CFG_LOCKED;
      end
    endcase
  end

  wdt_tick #(
    .CYCLES_PER_SEC(CYCLES_PER_SEC)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .restart_in(tick_restart),
    .tick_out(sec_tick)
  );

  // Nonzero unit counts minutes; seconds is the documented mode
  wire logic unit_secs = (counter_unit_reg_q == wdt_pkg::UNIT_SECONDS);
  wire logic min_wrap = (minute_q == wdt_pkg::SECS_PER_MIN - 6'h1);
  wire logic unit_tick = sec_tick && (unit_secs || min_wrap);
  wire logic counting = activate_reg_q[0] && enable_q &&
    counter_value_reg_q != 8'h00;
  wire logic dec = counting && unit_tick;
  wire logic expire = dec && counter_value_reg_q == 8'h01;

  always_comb begin
    minute_d = minute_q;
    if (tick_restart || min_wrap && sec_tick) begin
      minute_d = 6'h00;
    end else if (sec_tick) begin
      minute_d = minute_q + 6'h1;
    end
  end

  // Refresh wins over the same-cycle tick so a rewrite is never lost
  always_comb begin
    counter_value_reg_d = counter_value_reg_q;
    enable_d = enable_q;
    if (wr_refresh) begin
      counter_value_reg_d = {2'b00, timeout};
      enable_d = 1'b1;
    end else if (wr_cnt) begin
      counter_value_reg_d = io_req_in.wdata;
      enable_d = 1'b1;
    end else if (dec) begin
      counter_value_reg_d = counter_value_reg_q - 8'h01;
    end
    if (rd_refresh) begin
      enable_d = 1'b0;
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (io_req_in.rd) begin
      case (io_req_in.addr)
        wdt_pkg::PORT_INDEX: rdata_d = index_q;
        wdt_pkg::PORT_REFRESH: rdata_d = counter_value_reg_q;
        wdt_pkg::PORT_DATA: begin
          rdata_d = 8'h00;
          if (is_open && index_q == wdt_pkg::IDX_LDN) begin
            rdata_d = ldn_q;
          end else if (is_open && wd_sel) begin
            case (index_q)
              wdt_pkg::IDX_ACTIVATE: rdata_d = activate_reg_q;
              wdt_pkg::IDX_UNIT: rdata_d = counter_unit_reg_q;
              wdt_pkg::IDX_COUNT: rdata_d = counter_value_reg_q;
              default: rdata_d = 8'h00;
            endcase
          end
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Configuration space
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= wdt_pkg::CFG_LOCKED;
      index_q <= wdt_pkg::RST_INDEX;
      ldn_q <= wdt_pkg::RST_LDN;
      activate_reg_q <= wdt_pkg::RST_ACTIVATE;
      counter_unit_reg_q <= wdt_pkg::RST_UNIT;
    end else begin
      cfg_q <= cfg_d;
      index_q <= index_d;
      ldn_q <= ldn_d;
      activate_reg_q <= activate_reg_d;
      counter_unit_reg_q <= counter_unit_reg_d;
    end
  end

  // Countdown state
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      counter_value_reg_q <= wdt_pkg::RST_COUNT;
      minute_q <= 6'h00;
      enable_q <= 1'b0;
    end else begin
      counter_value_reg_q <= counter_value_reg_d;
      minute_q <= minute_d;
      enable_q <= enable_d;
    end
  end

  // Registered so read data stands until the next read
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // One-cycle pulse; stretching is left to the reset logic outside
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rst_pulse_q <= 1'b0;
    end else begin
      rst_pulse_q <= expire && !expire_irq_sel_in;
    end
  end

  // Interrupt holds until software touches the refresh port
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_q <= 1'b0;
    end else if (expire && expire_irq_sel_in) begin
      irq_q <= 1'b1;
    end else if (wr_refresh || rd_refresh) begin
      irq_q <= 1'b0;
    end
  end

  assign io_rdata_out = rdata_q;
  assign cpu_reset_out = rst_pulse_q;
  assign irq_out = irq_q;
  assign active_out = counting;
endmodule : wdt_top
`default_nettype wire

// File: wdt_monitor.sv
// Port assertions for the seconds watchdog.
// Assumes wdt_top ports and a short CYCLES_PER_SEC in sim.
`timescale 1ns/1ps
`default_nettype none
module wdt_monitor #(
  parameter int unsigned CYCLES_PER_SEC = 10
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire wdt_pkg::wdt_io_req_t io_req_in,
  input wire logic expire_irq_sel_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic cpu_reset_out,
  input wire logic irq_out,
  input wire logic active_out
);
  localparam int T_LO = CYCLES_PER_SEC;
  localparam int T_HI = CYCLES_PER_SEC + 3;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire logic hit = io_req_in.addr == wdt_pkg::PORT_REFRESH;
  wire logic acc = hit && (io_req_in.wr || io_req_in.rd);
  wire logic load = io_req_in.wr && (hit || io_req_in.addr == 16'h002f);
  wire logic fire = cpu_reset_out || irq_out;
  // Cycles since last possible load; saturates
  logic [7:0] cnt_q;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) cnt_q <= 8'h00;
    else if (load) cnt_q <= 8'h00;
    else if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
  end
  a_reset_pulse_one: assert property (cpu_reset_out |=> !cpu_reset_out)
    else $error("reset pulse too long");
  a_reset_sel: assert property (cpu_reset_out |-> !$past(expire_irq_sel_in))
    else $error("reset pulse in interrupt mode");
  a_irq_holds: assert property (irq_out && !acc |=> irq_out)
    else $error("interrupt dropped unasked");
  a_irq_fell: assert property ($fell(irq_out) |-> $past(acc))
    else $error("interrupt cleared without port access");
  a_read_disables: assert property (acc && io_req_in.rd |=> !active_out)
    else $error("still active after read");
  a_refresh_arms: assert property (acc && io_req_in.wr &&
    io_req_in.wdata[5:0] != 6'h00 |=> active_out)
    else $error("refresh did not arm");
  a_not_early: assert property (cpu_reset_out || $rose(irq_out) |->
    cnt_q >= CYCLES_PER_SEC - 1)
    else $error("expiry too early");
  a_on_time: assert property (acc && io_req_in.wr &&
    io_req_in.wdata == 8'hc1 |-> ##[T_LO:T_HI] fire)
    else $error("expiry missing or late");
  a_rdata_holds: assert property (!io_req_in.rd |=> $stable(io_rdata_out))
    else $error("read data moved without read");
  c_reset: cover property (cpu_reset_out);
  c_irq: cover property ($rose(irq_out));
  c_read: cover property (acc && io_req_in.rd);
endmodule : wdt_monitor
bind wdt_top wdt_monitor #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_mon (
  .clk_sys_in, .rst_in, .io_req_in, .expire_irq_sel_in, .io_rdata_out,
  .cpu_reset_out, .irq_out, .active_out);
`default_nettype wire

// File: test_wdt_top.sv
// Self-checking bench for the seconds watchdog top.
// Assumes an idle cycle between host I/O cycles is harmless.
`timescale 1ns/1ps
`default_nettype none
module test_wdt_top;
  localparam int unsigned CPS = 10;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic expire_irq_sel_in = 1'b0;
  wdt_pkg::wdt_io_req_t io_req_in = '0;
  logic [7:0] io_rdata_out;
  logic cpu_reset_out, irq_out, active_out;
  int fail_count = 0;
  int n_checks = 0;
  int n;
  // Port(3) write(1) data(2) expected rdata or active(2)
  logic [31:0] rows [20] = '{
    32'h02f00000, 32'h02e18700, 32'h02e18700, 32'h02e10700,
    32'h02f10800, 32'h02e1f600, 32'h02f10501, 32'h02f00005,
    32'h02e13001, 32'h02f10000, 32'h02f10101, 32'h02e1f501,
    32'h02f10001, 32'h02e1aa01, 32'h02e13001, 32'h02f10001,
    32'h44013f01, 32'h4400003f, 32'h44014101, 32'h12300000};
  wdt_top #(.CYCLES_PER_SEC(CPS)) uut (.clk_sys_in, .rst_in, .io_req_in,
    .expire_irq_sel_in, .io_rdata_out, .cpu_reset_out, .irq_out,
    .active_out);
  always #12.5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle strobe, then one idle cycle
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys_in);
    io_req_in <= '{a, w, !w, d};
    @(posedge clk_sys_in);
    io_req_in <= '0;
    #1;
  endtask : io
  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (1500) @(posedge clk_sys_in);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1 chk({io_rdata_out[4:0], cpu_reset_out, irq_out, active_out}, 8'h00);
    foreach (rows[i]) begin
      io({4'h0, rows[i][31:20]}, rows[i][16], rows[i][15:8]);
      chk(rows[i][16] ? {7'h0, active_out} : io_rdata_out, rows[i][7:0]);
    end
    // Early refresh must push expiry out
    io(16'h0440, 1'b1, 8'h41);
    repeat (6) @(posedge clk_sys_in);
    io(16'h0440, 1'b1, 8'hc1);
    n = 0;
    while (cpu_reset_out !== 1'b1 && n < 40) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk({7'h0, n >= CPS && n <= CPS + 2}, 8'h01);
    @(posedge clk_sys_in);
    expire_irq_sel_in <= 1'b1;
    io(16'h0440, 1'b1, 8'hc1);
    repeat (CPS + 6) @(posedge clk_sys_in);
    #1 chk({6'h0, irq_out, cpu_reset_out}, 8'h02);
    io(16'h0440, 1'b0, 8'h00);
    chk({7'h0, irq_out}, 8'h00);
    io(16'h0440, 1'b1, 8'h01);
    io(16'h0440, 1'b0, 8'h00);
    chk(io_rdata_out, 8'h01);
    repeat (CPS * 3) @(posedge clk_sys_in);
    #1 chk({6'h0, irq_out, active_out}, 8'h00);
    // Minutes unit must not count down on second ticks
    io(16'h002e, 1'b1, 8'h87);
    io(16'h002e, 1'b1, 8'h87);
    io(16'h002e, 1'b1, 8'hf5);
    io(16'h002f, 1'b1, 8'h01);
    io(16'h002e, 1'b1, 8'hf6);
    io(16'h002f, 1'b1, 8'h01);
    chk({7'h0, active_out}, 8'h01);
    repeat (CPS * 2 + 2) @(posedge clk_sys_in);
    io(16'h002f, 1'b0, 8'h00);
    chk({irq_out, io_rdata_out[6:0]}, 8'h01);
    io(16'h0440, 1'b0, 8'h00);
    print_verdict();
  end
endmodule : test_wdt_top
`default_nettype wire
